// >>> event_output_core.sv
/*
  event_output_core.sv
  holds the event-driven outputs, regulator overheat and drive termination
  status, bidirectional reset pin, keyed software reset and intrusion latch.
  assumes the serial bus front end delivers decoded byte register accesses
  on the core clock, and the analog part gives same-clock event flags.
*/
`include "event_output_map.svh"
module event_output_core #(
  parameter int HOLD_CYCLES = `RST_HOLD_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  // register access from the serial bus front end
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output      logic [7:0] reg_rdata_out,
  // analog-side events and battery reading, same clock
  input  wire logic       volt_event_in,
  input  wire logic       thermal_limit_pin_in,
  input  wire logic       fan_fail_event_in,
  input  wire logic [7:0] battery_voltage_channel_in,
  // pins, asynchronous
  input  wire logic [3:0] gpio_in,
  input  wire logic [1:0] regulator_overheat_input_in,
  input  wire logic [1:0] drive_termination_input_in,
  input  wire logic       intrusion_input_in,
  input  wire logic       battery_intrusion_in,
  input  wire logic       reset_pin_in,
  output      logic       reset_pin_out,
  output      logic       reset_pin_oe_out,
  output      logic [1:0] event_driven_output_out,
  output      logic [1:0] event_driven_output_oe_out,
  output      logic       fan_full_speed_out,
  output      logic       alert_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  event_output_pkg::core_state_t st;       // registered state
  event_output_pkg::core_state_t next_st;  // next state
  event_output_pkg::pin_sync_t   pins;     // synchronised pins
  logic       por_done;                    // power-up hold finished
  logic       hw_reset;                    // external reset seen
  logic       sw_reset;                    // keyed software reset
  logic       locked;                      // lock bit
  logic       intr_on;                     // intrusion monitoring alive
  logic [3:0] gpio_asserted;               // gpio after polarity
  logic [1:0] edo_event;                   // unmasked event per output
  logic [1:0] edo_level;                   // asserted state per output
  logic [1:0] edo_pol;                     // output polarity bits
  logic [1:0] vr_rise;                     // overheat assertion edges
  logic [1:0] term_rise;                   // termination assertion edges
  logic       intr_rise;                   // intrusion assertion edge

  // ****************************************************************
  // helpers
  // ****************************************************************
  // combine an event mask with the gpio and analog events
  function automatic logic mask_event(input logic [7:0] mask,
                                      input logic [3:0] gp,
                                      input logic       volt,
                                      input logic       thermal_limit_pin,
                                      input logic       fan);
    logic hit;
    hit = 1'b0;
    hit = hit | (volt  & ~mask[`BIT_MASK_VOLT]);
    hit = hit | (thermal_limit_pin & ~mask[`BIT_MASK_THERMAL_LIMIT_PIN]);
    hit = hit | (fan   & ~mask[`BIT_MASK_FAN]);
    hit = hit | (|(gp & ~mask[3:0]));
    return hit;
  endfunction

  // restore the set of registers that both soft and hard reset touch
  function automatic event_output_pkg::core_state_t reset_subset(
      input event_output_pkg::core_state_t s, input logic lk);
    event_output_pkg::core_state_t r;
    r = s;
    if (!lk) begin
      r.cfg0       = `RST_CFG0;
      r.cfg1       = `RST_CFG1;
      r.cfg2       = `RST_CFG2;
      r.cfg3       = `RST_CFG3;
      r.gpio_bhvr1 = `RST_ZERO;
      r.gpio_bhvr2 = `RST_ZERO;
      r.edo_enable = `RST_ZERO;
      r.edo_latch  = `RST_ZERO;
      r.vr_mask    = `RST_ZERO;
      r.dig_mask   = `RST_ZERO;
      r.mask_one   = `RST_ZERO;
      r.mask_two   = `RST_ZERO;
      r.edo_held   = 2'h0;
    end
    r.reset_key   = `RST_ZERO;
    r.thermal_limit_pin_stat2 = `RST_ZERO;
    r.dig_stat    = s.dig_stat & 8'h80;
    return r;
  endfunction

  // ****************************************************************
  // pin synchronisers and power-up timer
  // ****************************************************************
  sync_two_stage #(
    .WIDTH ($bits(event_output_pkg::pin_sync_t))
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .async_in    ({reset_pin_in, battery_intrusion_in, intrusion_input_in,
                   drive_termination_input_in, regulator_overheat_input_in,
                   gpio_in}),
    .rst_val_in  ('0),
    .sync_out    (pins)
  );

  reset_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .done_out    (por_done)
  );

  // ****************************************************************
  // reset pin and reset sources
  // ****************************************************************
  // drive pin low
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe_out = ~por_done;
  assign hw_reset = por_done & ~pins.reset_pin;
  assign sw_reset = reg_write_in && (reg_addr_in == `OFS_CFG0)
                    && reg_wdata_in[`BIT_SW_RESET]
                    && (st.reset_key == `SW_RESET_KEY);
  assign locked   = st.cfg1[`BIT_LOCK];

  // ****************************************************************
  // event decode
  // ****************************************************************
  // gpio polarity per pin
  assign gpio_asserted = {pins.gpio[3] ~^ st.gpio_bhvr1[6],
                          pins.gpio[2] ~^ st.gpio_bhvr1[4],
                          pins.gpio[1] ~^ st.gpio_bhvr1[2],
                          pins.gpio[0] ~^ st.gpio_bhvr1[0]};
  assign edo_event = {mask_event(st.mask_two, gpio_asserted, volt_event_in,
                                 thermal_limit_pin_in, fan_fail_event_in),
                      mask_event(st.mask_one, gpio_asserted, volt_event_in,
                                 thermal_limit_pin_in, fan_fail_event_in)};
  assign vr_rise   = pins.regulator_overheat_input & ~st.prev_in[1:0];
  assign term_rise = pins.term & ~st.prev_in[3:2];
  assign intr_rise = pins.intrusion & ~st.prev_in[4];
  assign intr_on   = battery_voltage_channel_in >= st.batt_limit;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.prev_in = {pins.intrusion, pins.term, pins.regulator_overheat_input};
    // register writes
    if (reg_write_in) begin
      case (reg_addr_in)
        `OFS_CFG0:       next_st.cfg0 = {1'b0, reg_wdata_in[6:0]};
        `OFS_CFG1:       next_st.cfg1 = reg_wdata_in;
        `OFS_CFG2:       next_st.cfg2 = reg_wdata_in;
        `OFS_CFG3:       next_st.cfg3 = reg_wdata_in;
        `OFS_GPIO_BHVR1: next_st.gpio_bhvr1 = reg_wdata_in;
        `OFS_GPIO_BHVR2: next_st.gpio_bhvr2 = reg_wdata_in;
        `OFS_EDO_ENABLE: next_st.edo_enable = reg_wdata_in;
        `OFS_EDO_LATCH:  next_st.edo_latch = reg_wdata_in;
        `OFS_VR_MASK:    next_st.vr_mask = reg_wdata_in;
        `OFS_DIG_MASK:   next_st.dig_mask = reg_wdata_in;
        `OFS_MASK_ONE:   next_st.mask_one = reg_wdata_in;
        `OFS_MASK_TWO:   next_st.mask_two = reg_wdata_in;
        `OFS_BATT_LIMIT: next_st.batt_limit = reg_wdata_in;
        `OFS_RESET_KEY:  next_st.reset_key = reg_wdata_in;
        default:         ;
      endcase
    end
    // reads return registered data; status reads clear sticky bits, except intrusion bit 7 of dig_stat
    if (reg_read_in) begin
      case (reg_addr_in)
        `OFS_CFG0:          next_st.rdata = st.cfg0;
        `OFS_CFG1:          next_st.rdata = st.cfg1;
        `OFS_CFG2:          next_st.rdata = st.cfg2;
        `OFS_CFG3:          next_st.rdata = st.cfg3;
        `OFS_GPIO_BHVR1:    next_st.rdata = st.gpio_bhvr1;
        `OFS_GPIO_BHVR2:    next_st.rdata = st.gpio_bhvr2;
        `OFS_EDO_ENABLE:    next_st.rdata = st.edo_enable;
        `OFS_EDO_LATCH:     next_st.rdata = st.edo_latch;
        `OFS_VR_MASK:       next_st.rdata = st.vr_mask;
        `OFS_DIG_MASK:      next_st.rdata = st.dig_mask;
        `OFS_MASK_ONE:      next_st.rdata = st.mask_one;
        `OFS_MASK_TWO:      next_st.rdata = st.mask_two;
        `OFS_BATT_LIMIT:    next_st.rdata = st.batt_limit;
        `OFS_RESET_KEY:     next_st.rdata = st.reset_key;
        `OFS_BATT_READING:  next_st.rdata = battery_voltage_channel_in;
        `OFS_THERMAL_LIMIT_PIN_STAT2_H,
        `OFS_THERMAL_LIMIT_PIN_STAT2_M: begin
          next_st.rdata       = st.thermal_limit_pin_stat2;
          next_st.thermal_limit_pin_stat2 = 8'h00;
        end
        `OFS_DIG_STAT_H,
        `OFS_DIG_STAT_M: begin
          next_st.rdata    = st.dig_stat;
          next_st.dig_stat = st.dig_stat & 8'h80;
        end
        default:            next_st.rdata = 8'h00;
      endcase
    end
    if (st.cfg3[`BIT_CI_CLEAR]) begin
      next_st.dig_stat[`BIT_INTRUSION] = 1'b0;
    end
    // overheat and termination sticky status, set wins over read clear
    next_st.thermal_limit_pin_stat2[1:0] = next_st.thermal_limit_pin_stat2[1:0] | vr_rise;
    next_st.dig_stat[5:4] = next_st.dig_stat[5:4] | term_rise;
    // intrusion latch, battery-side event after power returns
    if (intr_on && (intr_rise || pins.batt_intr)) begin
      next_st.dig_stat[`BIT_INTRUSION] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (!st.edo_enable[i] || !st.edo_latch[i]) begin
        next_st.edo_held[i] = 1'b0;
      end else if (edo_event[i]) begin
        next_st.edo_held[i] = 1'b1;
      end
    end
    // hard and soft reset share one subset
    if (hw_reset || sw_reset) begin
      next_st = reset_subset(next_st, locked);
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-on defaults
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st             <= '0;
      st.cfg0        <= `RST_CFG0;
      st.cfg1        <= `RST_CFG1;
      st.cfg2        <= `RST_CFG2;
      st.cfg3        <= `RST_CFG3;
      st.batt_limit  <= `RST_BATT_LIMIT;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out = st.rdata;
  assign edo_pol       = {st.gpio_bhvr2[2], st.gpio_bhvr2[0]};
  assign edo_level = st.edo_enable[1:0]
                     & (st.edo_held | (edo_event & ~st.edo_latch[1:0]));
  // open-drain pin of an enabled output pulled low when its level differs from its polarity bit
  assign event_driven_output_out    = 2'h0;
  assign event_driven_output_oe_out = st.edo_enable[1:0]
                                      & ~(edo_level ~^ edo_pol);
  assign fan_full_speed_out = (pins.regulator_overheat_input[0] & st.cfg2[`BIT_BOOST_ONE])
                              | (pins.regulator_overheat_input[1] & st.cfg2[`BIT_BOOST_TWO]);
  assign alert_out = (|(st.thermal_limit_pin_stat2[1:0] & ~st.vr_mask[1:0]))
                     | (|(st.dig_stat[5:4] & ~st.dig_mask[5:4]))
                     | (st.dig_stat[`BIT_INTRUSION] & ~st.dig_mask[`BIT_INTRUSION]);

endmodule

// >>> event_output_map.svh
/*
  event_output_map.svh
  holds the register offsets, bit positions, reset values and timing counts
  of the event-output and reset logic of the system monitor.
  assumes it is included by bare name and that the core clock runs at 40 MHz.
*/
// Notes on behaviour
// - any of gpio one to four latches outputs
// - one event mask per output, 0x37/0x38
// - polarity bit sets output active level
// - mask bits 7:5 gate voltage, thermal, fan
// - latch only when latch enable bit set
// - mask bits 3:0 exclude gpio4..gpio1, or-ed
// - regulator overheat sets thermal status two bits
// - overheat plus boost enable forces full fans
// - register 0x31 masks overheat from alert
// - termination inputs set status bits 4, 5
// - register 0x35 masks termination from alert
// - hold reset pin low 180 ms after power
// - power-on reset restores every register default
// - external low on reset pin resets device
// - hardware reset spares limits and locked registers
// - software reset needs key 0x6d at 0x7b
// - key cleared after reset; same reset set
// - intrusion rising edge latches bit 7, alerts
// - intrusion bit held until clear bit written
// - intrusion off while battery below limit
// - battery-side intrusion reported once power returns
`ifndef EVENT_OUTPUT_MAP_SVH
`define EVENT_OUTPUT_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CFG0          8'h00
`define OFS_CFG1          8'h01
`define OFS_CFG2          8'h02
`define OFS_CFG3          8'h03
`define OFS_GPIO_BHVR1    8'h09
`define OFS_GPIO_BHVR2    8'h0a
`define OFS_EDO_ENABLE    8'h16
`define OFS_EDO_LATCH     8'h17
`define OFS_VR_MASK       8'h31
`define OFS_DIG_MASK      8'h35
`define OFS_MASK_ONE      8'h37
`define OFS_MASK_TWO      8'h38
`define OFS_BATT_LIMIT    8'h75
`define OFS_RESET_KEY     8'h7b
`define OFS_BATT_READING  8'h93
`define OFS_THERMAL_LIMIT_PIN_STAT2_H 8'hb9
`define OFS_DIG_STAT_H    8'hbe
`define OFS_THERMAL_LIMIT_PIN_STAT2_M 8'hc1
`define OFS_DIG_STAT_M    8'hc6

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CFG0       8'h20
`define RST_CFG1       8'h81
`define RST_CFG2       8'h80
`define RST_CFG3       8'h00
`define RST_ZERO       8'h00
`define RST_BATT_LIMIT 8'h80
`define SW_RESET_KEY   8'h6d

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_SW_RESET   7
`define BIT_LOCK       6
`define BIT_BOOST_ONE  3
`define BIT_BOOST_TWO  4
`define BIT_CI_CLEAR   5
`define BIT_MASK_VOLT  7
`define BIT_MASK_THERMAL_LIMIT_PIN 6
`define BIT_MASK_FAN   5
`define BIT_TERM_LO    4
`define BIT_INTRUSION  7

// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_HZ    40000000
`define RST_HOLD_MS    180
`define RST_HOLD_CYC   ((`CLK_FREQ_HZ / 1000) * `RST_HOLD_MS)

`endif

// >>> event_output_pkg.sv
/*
  event_output_pkg.sv
  holds the packed types shared by the event-output and reset logic.
  assumes event_output_map.svh is compiled alongside.
*/
package event_output_pkg;

  // ****************************************************************
  // register file and event state of the core
  // ****************************************************************
  typedef struct packed {
    logic [7:0] cfg0;          // software reset and misc config
    logic [7:0] cfg1;          // holds the lock bit
    logic [7:0] cfg2;          // boost enables
    logic [7:0] cfg3;          // intrusion clear bit
    logic [7:0] gpio_bhvr1;    // gpio1..4 direction/polarity
    logic [7:0] gpio_bhvr2;    // gpio5..8 direction/polarity
    logic [7:0] edo_enable;    // output enables
    logic [7:0] edo_latch;     // output latch enables
    logic [7:0] vr_mask;       // overheat alert mask
    logic [7:0] dig_mask;      // termination/intrusion alert mask
    logic [7:0] mask_one;      // output one event mask
    logic [7:0] mask_two;      // output two event mask
    logic [7:0] batt_limit;    // battery lower limit
    logic [7:0] reset_key;     // software reset key
    logic [7:0] thermal_limit_pin_stat2;   // sticky overheat status
    logic [7:0] dig_stat;      // sticky termination/intrusion status
    logic [7:0] rdata;         // read data
    logic [1:0] edo_held;      // latched output state
    logic [4:0] prev_in;       // previous synced event levels
  } core_state_t;

  // ****************************************************************
  // synchronised pin inputs
  // ****************************************************************
  typedef struct packed {
    logic       reset_pin;     // reset pin level
    logic       batt_intr;     // battery-side intrusion latch
    logic       intrusion;     // intrusion input
    logic [1:0] term;          // drive termination inputs
    logic [1:0] regulator_overheat_input;        // regulator overheat inputs
    logic [3:0] gpio;          // gpio1..4 pin levels
  } pin_sync_t;

endpackage

// >>> sync_two_stage.sv
/*
  sync_two_stage.sv
  holds a two flip-flop synchroniser for a bundle of level inputs.
  assumes the inputs are quasi-static levels from outside the clock domain.
*/
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;  // first stage, read only by second stage

  // ****************************************************************
  // two stage capture
  // ****************************************************************
  // two flop sync
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> reset_hold_timer.sv
/*
  reset_hold_timer.sv
  holds the power-up counter that keeps the reset pin driven low.
  assumes rstn_in is the device power-on reset.
*/
`include "event_output_map.svh"
module reset_hold_timer #(
  parameter int HOLD_CYCLES = `RST_HOLD_CYC
) (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  output      logic done_out
);

  logic [31:0] count;  // cycles since power-on release

  // ****************************************************************
  // count up to the hold time, then stop
  // ****************************************************************
  // power-up hold
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count    <= 32'h0000_0000;
      done_out <= 1'b0;
    end else if (count >= 32'(HOLD_CYCLES - 1)) begin
      done_out <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule

// >>> reset_pin_model.sv
/*
  reset_pin_model.sv
  holds the board side of the reset pin: a pull-up and an outside reset
  circuit that can sink the pin.
  assumes the device sinks the pin while its output enable is high.
*/
module reset_pin_model (
  input  wire logic oe_in,     // device sinks the pin
  input  wire logic pull_in,   // outside circuit sinks the pin
  output      logic level_out  // resolved pin level
);
  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // device sink or outside pulse, pull-up otherwise
  assign level_out = !(oe_in || pull_in);
endmodule

// >>> event_output_chk.sv
/*
  event_output_chk.sv
  holds the port checker of the event-output and reset core.
  assumes it is bound to event_output_core and sees only its ports.
*/
module event_output_chk #(
  parameter int HOLD_CYCLES = 20
) (
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [1:0] regulator_overheat_input_in,
  input wire logic       reset_pin_in,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe_out,
  input wire logic [1:0] event_driven_output_out,
  input wire logic [1:0] event_driven_output_oe_out,
  input wire logic       fan_full_speed_out,
  input wire logic       alert_out
);
  // ****************************************************************
  // helper logic: hold counter and write shadows
  // ****************************************************************
  int         cnt;   // edges since power-on release
  logic [1:0] en_z;  // output enable known to be zero
  logic       m31;   // overheat alert fully masked
  logic       m35;   // digital alert fully masked
  // mask shadows (not en_z) are dropped on any reset that could restore defaults
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt  <= 0;
      en_z <= 2'b11;
      m31  <= 1'b0;
      m35  <= 1'b0;
    end else begin
      if (cnt < HOLD_CYCLES + 4) cnt <= cnt + 1;
      if (reg_write_in && reg_addr_in == 8'h16) en_z <= ~reg_wdata_in[1:0];
      if (reg_write_in && reg_addr_in == 8'h31) m31 <= &reg_wdata_in[1:0];
      if (reg_write_in && reg_addr_in == 8'h35) m35 <= &{reg_wdata_in[7], reg_wdata_in[5:4]};
      if (!reset_pin_in || (reg_write_in && reg_addr_in == 8'h00)) begin
        m31 <= 1'b0;
        m35 <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_hold_high: assert property (cnt < HOLD_CYCLES |-> reset_pin_oe_out)
    else $error("reset pin released early");
  a_hold_low: assert property (cnt >= HOLD_CYCLES |-> !reset_pin_oe_out)
    else $error("reset pin held too long");
  a_pin_sink: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_edo_sink: assert property (event_driven_output_out == 2'b00)
    else $error("event output driven high");
  a_rdata_hold: assert property (!$past(reg_read_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without read");
  a_fan_cause: assert property (fan_full_speed_out |->
    |($past(regulator_overheat_input_in) | $past(regulator_overheat_input_in, 2)
      | $past(regulator_overheat_input_in, 3)))
    else $error("fan boost without overheat");
  a_edo_off: assert property ((event_driven_output_oe_out & en_z) == 2'b00)
    else $error("disabled event output active");
  a_alert_masked: assert property (m31 && m35 && $past(m31 && m35) |-> !alert_out)
    else $error("alert despite masks");
endmodule

bind event_output_core event_output_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

// >>> test_event_output_and_reset_logic.sv
/*
  test_event_output_and_reset_logic.sv
  holds the self-checking bench of the event-output and reset core.
  assumes a 40 MHz core clock and a shortened power-up hold.
*/
module test_event_output_and_reset_logic;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 20;  // shortened power-up hold
  logic core_clk_in, rstn_in, reg_write_in, reg_read_in, volt_event_in;
  logic thermal_limit_pin_in, fan_fail_event_in, intrusion_input_in;
  logic battery_intrusion_in, reset_pin_in, pull, reset_pin_out, reset_pin_oe_out;
  logic fan_full_speed_out, alert_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, battery_voltage_channel_in;
  logic [3:0] gpio_in;
  logic [1:0] regulator_overheat_input_in, drive_termination_input_in;
  logic [1:0] event_driven_output_out, event_driven_output_oe_out;
  int fail_count, compares;
  logic [15:0] dflt [6] = '{16'h0020, 16'h0181, 16'h0280, 16'h7580, 16'h3700, 16'h7b00};
  event_output_core #(.HOLD_CYCLES(HOLD)) uut (.*);
  reset_pin_model model (.oe_in(reset_pin_oe_out), .pull_in(pull), .level_out(reset_pin_in));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask
  // read data checked just after the answer edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  // outside reset pulse longer than the minimum width
  task automatic pulse;
    w(1);
    pull <= 1'b1;
    w(32004);
    pull <= 1'b0;
    w(6);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_power;
    #1 chk(reset_pin_in, 1'b0);
    w(HOLD + 5);
    #1 chk(reset_pin_in, 1'b1);
    foreach (dflt[i]) rd(dflt[i][15:8], dflt[i][7:0]);
    wr(8'h37, 8'h0e);
    wr(8'h38, 8'hf7);
    rd(8'h37, 8'h0e);
    rd(8'h38, 8'hf7);
    rd(8'h40, 8'h00);
    $display("power and mask done");
  endtask
  task automatic t_edo;
    wr(8'h09, 8'h55);
    wr(8'h16, 8'h03);
    for (int k = 0; k < 5; k++) begin
      w(1);
      gpio_in <= 4'h1 << k;
      w(5);
      #1 chk(event_driven_output_oe_out, {k == 3, k == 0});
    end
    for (int k = 0; k < 3; k++) begin
      w(1);
      {volt_event_in, thermal_limit_pin_in, fan_fail_event_in} <= 3'h4 >> k;
      w(2);
      #1 chk(event_driven_output_oe_out, 2'b01);
    end
    w(1);
    {volt_event_in, thermal_limit_pin_in, fan_fail_event_in} <= 3'h0;
    wr(8'h17, 8'h01);
    gpio_in <= 4'h1;
    w(5);
    gpio_in <= 4'h0;
    w(5);
    #1 chk(event_driven_output_oe_out, 2'b01);
    wr(8'h0a, 8'h01);
    #1 chk(event_driven_output_oe_out, 2'b00);
    $display("event output done");
  endtask
  task automatic t_status;
    wr(8'h02, 8'h88);
    regulator_overheat_input_in <= 2'b01;
    w(5);
    #1 chk(fan_full_speed_out, 1'b1);
    w(1);
    regulator_overheat_input_in <= 2'b10;
    w(5);
    #1 chk(fan_full_speed_out, 1'b0);
    chk(alert_out, 1'b1);
    wr(8'h31, 8'h03);
    w(2);
    #1 chk(alert_out, 1'b0);
    rd(8'hb9, 8'h03);
    rd(8'hc1, 8'h00);
    w(1);
    drive_termination_input_in <= 2'b11;
    w(5);
    #1 chk(alert_out, 1'b1);
    wr(8'h35, 8'hb0);
    w(2);
    #1 chk(alert_out, 1'b0);
    rd(8'hc6, 8'h30);
    $display("status done");
  endtask
  task automatic t_intr;
    w(1);
    intrusion_input_in <= 1'b1;
    w(5);
    intrusion_input_in <= 1'b0;
    rd(8'hbe, 8'h80);
    rd(8'hbe, 8'h80);
    wr(8'h03, 8'h20);
    wr(8'h03, 8'h00);
    rd(8'hbe, 8'h00);
    w(1);
    battery_voltage_channel_in <= 8'h10;
    intrusion_input_in <= 1'b1;
    w(5);
    intrusion_input_in <= 1'b0;
    rd(8'hbe, 8'h00);
    w(1);
    battery_voltage_channel_in <= 8'h90;
    battery_intrusion_in <= 1'b1;
    w(5);
    battery_intrusion_in <= 1'b0;
    rd(8'hbe, 8'h80);
    $display("intrusion done");
  endtask
  task automatic t_reset;
    wr(8'h37, 8'h55);
    wr(8'h00, 8'h80);
    rd(8'h37, 8'h55);
    wr(8'h7b, 8'h6d);
    wr(8'h00, 8'h80);
    rd(8'h37, 8'h00);
    rd(8'h7b, 8'h00);
    wr(8'h38, 8'h12);
    pulse();
    rd(8'h38, 8'h00);
    wr(8'h01, 8'hc1);
    wr(8'h38, 8'h12);
    pulse();
    rd(8'h38, 8'h12);
    $display("reset done");
  endtask
  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (80000) @(posedge core_clk_in);
    fail_count++;
    wrap_up();
  end
  initial begin
    {rstn_in, reg_write_in, reg_read_in, volt_event_in, thermal_limit_pin_in} = 5'h0;
    {fan_fail_event_in, intrusion_input_in, battery_intrusion_in, pull} = 4'h0;
    {reg_addr_in, reg_wdata_in, gpio_in} = 20'h0;
    {regulator_overheat_input_in, drive_termination_input_in} = 4'h0;
    battery_voltage_channel_in = 8'h90;
    w(16);
    rstn_in <= 1'b1;
    t_power();
    t_edo();
    t_status();
    t_intr();
    t_reset();
    wrap_up();
  end
endmodule
